// ### include/nomw_cfg.svh
// Constants for the network object map and communication watchdog.
`ifndef NOMW_CFG_SVH
`define NOMW_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and watchdog timing
// ----------------------------------------------------------------------------
`define NOMW_CLK_PERIOD_NS 20
`define NOMW_TICK_MS 100
`define NOMW_TICK_CYCLES ((`NOMW_TICK_MS * 1000000) / `NOMW_CLK_PERIOD_NS)
`define NOMW_PRESC_W 23

// ----------------------------------------------------------------------------
// Object counts and analog object indices (zero based)
// ----------------------------------------------------------------------------
`define NOMW_AO_COUNT 5'h0C
`define NOMW_BI_COUNT 5'h18
`define NOMW_BO_COUNT 5'h15
`define NOMW_BI_STATUS_LAST 5'h10
`define NOMW_BO_CTRL_LAST 5'h10
`define NOMW_AO_ACCEL 0
`define NOMW_AO_DECEL 1
`define NOMW_AO_SPEED_REF 2
`define NOMW_AO_VALUE_A 3
`define NOMW_AO_VALUE_B 4
`define NOMW_AO_UPP_A 5
`define NOMW_AO_UPP_B 6
`define NOMW_AO_UPP_C 7
`define NOMW_AO_MPID_AUTO 8
`define NOMW_AO_MPID_MAN 9
`define NOMW_AO_EPID_AUTO 10
`define NOMW_AO_EPID_MAN 11

// ----------------------------------------------------------------------------
// Ranges, field positions and reset values
// ----------------------------------------------------------------------------
`define NOMW_RAMP_MAX 16'h2706
`define NOMW_PCT_MAX 16'h03E8
`define NOMW_CTRL_USED_MASK 16'h60FF
`define NOMW_CTRL_FWD_BIT 2
`define NOMW_CTRL_FAULT_RESET_BIT 7
`define NOMW_STAT_ALARM_BIT 7
`define NOMW_STAT_FAULT_BIT 15
`define NOMW_WORD_RESET 16'h0000
`define NOMW_DOUT_RESET 5'h00

`endif

// ### include/nomw_pkg.sv
// Types for the network object map and communication watchdog.
package nomw_pkg;

	typedef enum logic [1:0] {
		analog_write_object = 2'h0,
		binary_read_object = 2'h1,
		binary_write_object = 2'h2
	} nomw_kind_type;

	typedef enum logic [2:0] {
		WD_IDLE = 3'h1,
		WD_ARMED = 3'h2,
		WD_EXPIRED = 3'h4
	} nomw_wd_type;

	typedef struct packed {
		nomw_wd_type wd_state;
		logic [22:0] presc;
		logic [15:0] remain;
		logic comm_alarm;
		logic comm_fault;
		logic [11:0][15:0] ao_mem;
		logic [15:0] ctrl;
		logic [4:0] dout;
		logic rsp_valid;
		logic rsp_error;
		logic [15:0] rsp_data;
		logic fault_reset_pulse;
		logic dir_forward;
		logic [14:0] ao_level_a;
		logic [14:0] ao_level_b;
	} nomw_state_type;

endpackage

// ### src/nomw_top.sv
// Network object map with communication-loss watchdog.
`timescale 1ns/1ps
`include "nomw_cfg.svh"

// Behaviour
// - Active watchdog expects telegram within each period.
// - Only address- and check-correct telegrams restart timing.
// - Timing starts after first valid telegram only.
// - Timeout raises alarm or fault per selection.
// - Alarm clears itself when valid telegrams resume.
// - Period value zero disables the watchdog.
// - Watchdog independent of active serial protocol.
// - Status word bits 1-15 carry drive flags.
// - Enabled bit 9, forward bit 10 meanings.
// - Digital inputs one to eight, read-only bits.
// - Control word bits 0-7 take command flags.
// - Bit 7 requests fault reset; 8-12,15 unused.
// - Bits 13,14 select manual PID modes.
// - Digital output word, outputs one-five, read-write.
// - Ramp times read-write, range 0.0 to 999.0.
// - Speed reference signed, full 16-bit range.
// - Three user parameters, unsigned 0 to 65535.
// - Manual setpoints 0-100.0%, automatic setpoints signed.
// - Direction combines control bit 2 and sign.
// - Analog output scaled 15 bits, 7FFFh full.
module nomw_top #(
	parameter int unsigned TICK_CYCLES = `NOMW_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic telegram_ok,
	input wire logic req_valid,
	input wire logic req_write,
	input wire nomw_pkg::nomw_kind_type req_kind,
	input wire logic [4:0] req_index,
	input wire logic [15:0] req_wdata,
	input wire logic [15:0] comm_timeout_period,
	input wire logic comm_loss_action_select,
	input wire logic [15:0] drive_status_flags,
	input wire logic [7:0] digital_input_state,
	output logic rsp_valid,
	output logic rsp_error,
	output logic [15:0] rsp_data,
	output logic comm_timeout_alarm,
	output logic comm_timeout_fault,
	output logic fault_reset_req,
	output logic [15:0] drive_control_word,
	output logic [4:0] digital_output_setting,
	output logic dir_forward,
	output logic [14:0] ao_level_a,
	output logic [14:0] ao_level_b,
	output logic [15:0] accel_time,
	output logic [15:0] decel_time,
	output logic [15:0] net_speed_reference,
	output logic [15:0] analog_out_value_a,
	output logic [15:0] analog_out_value_b,
	output logic [15:0] user_prog_param_a,
	output logic [15:0] user_prog_param_b,
	output logic [15:0] user_prog_param_c,
	output logic [15:0] main_pid_auto_setpoint,
	output logic [15:0] main_pid_manual_setpoint,
	output logic [15:0] ext_pid_auto_setpoint,
	output logic [15:0] ext_pid_manual_setpoint
);

	localparam logic [22:0] PRESC_LOAD = 23'(TICK_CYCLES - 1);
	localparam logic [15:0] CTRL_USED = `NOMW_CTRL_USED_MASK;

	nomw_pkg::nomw_state_type state_reg;
	nomw_pkg::nomw_state_type state_next;
	logic [15:0] status_word;

	// ------------------------------------------------------------------------
	// Status word assembly
	// ------------------------------------------------------------------------
	// drive flags on bits 1 to 15, watchdog merged in.
	// enabled and forward flags pass through.
	always_comb begin
		status_word = {drive_status_flags[15:1], 1'b0};
		status_word[`NOMW_STAT_ALARM_BIT] = drive_status_flags[`NOMW_STAT_ALARM_BIT] | state_reg.comm_alarm;
		status_word[`NOMW_STAT_FAULT_BIT] = drive_status_flags[`NOMW_STAT_FAULT_BIT] | state_reg.comm_fault;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		logic [4:0] pos;
		logic range_ok;
		logic fault_clear;
		logic fwd_bit;
		pos = 5'h00;
		range_ok = 1'b1;
		fault_clear = 1'b0;
		fwd_bit = 1'b0;
		state_next = state_reg;
		state_next.rsp_valid = 1'b0;
		state_next.fault_reset_pulse = 1'b0;
		if (req_valid) begin
			state_next.rsp_valid = 1'b1;
			state_next.rsp_error = 1'b0;
			state_next.rsp_data = 16'h0000;
			pos = req_index - 5'h01;
			unique case (req_kind)
				nomw_pkg::analog_write_object: begin
					if (req_index == 5'h00 || req_index > `NOMW_AO_COUNT) begin
						state_next.rsp_error = 1'b1;
					end else begin
						// ramp times refused above 999.0 s.
						if (pos == 5'(`NOMW_AO_ACCEL) || pos == 5'(`NOMW_AO_DECEL)) begin
							range_ok = req_wdata <= `NOMW_RAMP_MAX;
						end
						// manual setpoints refused above 100.0 percent.
						if (pos == 5'(`NOMW_AO_MPID_MAN) || pos == 5'(`NOMW_AO_EPID_MAN)) begin
							range_ok = req_wdata <= `NOMW_PCT_MAX;
						end
						if (req_write) begin
							// signed and unsigned objects take the full word.
							if (range_ok) begin
								state_next.ao_mem[pos[3:0]] = req_wdata;
							end else begin
								state_next.rsp_error = 1'b1;
							end
						end
						state_next.rsp_data = state_next.ao_mem[pos[3:0]];
					end
				end
				nomw_pkg::binary_read_object: begin
					// inputs follow the status word objects.
					if (req_index == 5'h00 || req_index > `NOMW_BI_COUNT || req_write) begin
						state_next.rsp_error = 1'b1;
					end else if (req_index <= `NOMW_BI_STATUS_LAST) begin
						state_next.rsp_data = {15'h0000, status_word[pos[3:0]]};
					end else begin
						state_next.rsp_data = {15'h0000, digital_input_state[3'(pos - 5'h10)]};
					end
				end
				nomw_pkg::binary_write_object: begin
					if (req_index == 5'h00 || req_index > `NOMW_BO_COUNT) begin
						state_next.rsp_error = 1'b1;
					end else if (req_index <= `NOMW_BO_CTRL_LAST) begin
						if (req_write && CTRL_USED[pos[3:0]]) begin
							state_next.ctrl[pos[3:0]] = req_wdata[0];
						end
						// a one written to bit 7 fires a reset request.
						if (req_write && pos == 5'(`NOMW_CTRL_FAULT_RESET_BIT) && req_wdata[0]) begin
							state_next.fault_reset_pulse = 1'b1;
							fault_clear = 1'b1;
						end
						state_next.rsp_data = {15'h0000, state_next.ctrl[pos[3:0]]};
					end else begin
						// outputs one to five on bits 0 to 4.
						if (req_write) begin
							state_next.dout[3'(pos - 5'h10)] = req_wdata[0];
						end
						state_next.rsp_data = {15'h0000, state_next.dout[3'(pos - 5'h10)]};
					end
				end
				default: begin
					state_next.rsp_error = 1'b1;
				end
			endcase
		end

		// The fault is cleared first so a timeout in the same cycle still wins.
		if (fault_clear) begin
			state_next.comm_fault = 1'b0;
		end

		// the watchdog sees only the valid-telegram strobe, not the framing.
		if (comm_timeout_period == 16'h0000) begin
			state_next.wd_state = nomw_pkg::WD_IDLE;
			state_next.comm_alarm = 1'b0;
		end else if (telegram_ok) begin
			// full reload on each valid telegram.
			state_next.wd_state = nomw_pkg::WD_ARMED;
			state_next.remain = comm_timeout_period;
			state_next.presc = PRESC_LOAD;
			// a resumed link removes the alarm.
			state_next.comm_alarm = 1'b0;
		end else begin
			unique case (state_reg.wd_state)
				// no timing before the first valid telegram.
				nomw_pkg::WD_IDLE: begin
					state_next.wd_state = nomw_pkg::WD_IDLE;
				end
				nomw_pkg::WD_ARMED: begin
					if (state_reg.presc != 23'h000000) begin
						state_next.presc = state_reg.presc - 23'h000001;
					end else begin
						state_next.presc = PRESC_LOAD;
						state_next.remain = state_reg.remain - 16'h0001;
						if (state_reg.remain <= 16'h0001) begin
							state_next.wd_state = nomw_pkg::WD_EXPIRED;
							if (comm_loss_action_select) begin
								state_next.comm_fault = 1'b1;
							end else begin
								state_next.comm_alarm = 1'b1;
							end
						end
					end
				end
				nomw_pkg::WD_EXPIRED: begin
					state_next.wd_state = nomw_pkg::WD_EXPIRED;
				end
				default: begin
					state_next.wd_state = nomw_pkg::WD_IDLE;
				end
			endcase
		end

		// direction from control bit 2 and the reference sign.
		fwd_bit = state_next.ctrl[`NOMW_CTRL_FWD_BIT];
		state_next.dir_forward = fwd_bit ^ state_next.ao_mem[`NOMW_AO_SPEED_REF][15];
		// negative values clamp to zero on the 15-bit output scale.
		state_next.ao_level_a = state_next.ao_mem[`NOMW_AO_VALUE_A][15] ? 15'h0000 :
			state_next.ao_mem[`NOMW_AO_VALUE_A][14:0];
		state_next.ao_level_b = state_next.ao_mem[`NOMW_AO_VALUE_B][15] ? 15'h0000 :
			state_next.ao_mem[`NOMW_AO_VALUE_B][14:0];
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.wd_state <= nomw_pkg::WD_IDLE;
			state_reg.ctrl <= `NOMW_WORD_RESET;
			state_reg.dout <= `NOMW_DOUT_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign rsp_valid = state_reg.rsp_valid;
	assign rsp_error = state_reg.rsp_error;
	assign rsp_data = state_reg.rsp_data;
	assign comm_timeout_alarm = state_reg.comm_alarm;
	assign comm_timeout_fault = state_reg.comm_fault;
	assign fault_reset_req = state_reg.fault_reset_pulse;
	// command flags and PID mode bits leave as stored.
	assign drive_control_word = state_reg.ctrl;
	assign digital_output_setting = state_reg.dout;
	assign dir_forward = state_reg.dir_forward;
	assign ao_level_a = state_reg.ao_level_a;
	assign ao_level_b = state_reg.ao_level_b;
	assign accel_time = state_reg.ao_mem[`NOMW_AO_ACCEL];
	assign decel_time = state_reg.ao_mem[`NOMW_AO_DECEL];
	assign net_speed_reference = state_reg.ao_mem[`NOMW_AO_SPEED_REF];
	// value objects feed the analog outputs.
	assign analog_out_value_a = state_reg.ao_mem[`NOMW_AO_VALUE_A];
	assign analog_out_value_b = state_reg.ao_mem[`NOMW_AO_VALUE_B];
	// user parameters are plain unsigned words.
	assign user_prog_param_a = state_reg.ao_mem[`NOMW_AO_UPP_A];
	assign user_prog_param_b = state_reg.ao_mem[`NOMW_AO_UPP_B];
	assign user_prog_param_c = state_reg.ao_mem[`NOMW_AO_UPP_C];
	assign main_pid_auto_setpoint = state_reg.ao_mem[`NOMW_AO_MPID_AUTO];
	assign main_pid_manual_setpoint = state_reg.ao_mem[`NOMW_AO_MPID_MAN];
	assign ext_pid_auto_setpoint = state_reg.ao_mem[`NOMW_AO_EPID_AUTO];
	assign ext_pid_manual_setpoint = state_reg.ao_mem[`NOMW_AO_EPID_MAN];

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	never_armed_a: assert property (
		$rose(state_reg.comm_alarm | state_reg.comm_fault) |-> $past(state_reg.wd_state) == nomw_pkg::WD_ARMED)
		else $error("watchdog flag rose without an armed timer");

	reload_full_a: assert property (
		telegram_ok && comm_timeout_period != 16'h0000 |=>
		state_reg.remain == $past(comm_timeout_period) && state_reg.presc == PRESC_LOAD)
		else $error("valid telegram did not reload the full period");

	noise_holds_a: assert property (
		!telegram_ok && state_reg.wd_state == nomw_pkg::WD_ARMED && state_reg.presc != 23'h000000 &&
		comm_timeout_period != 16'h0000 |=> state_reg.remain == $past(state_reg.remain))
		else $error("timer moved without a tick or valid telegram");

	action_select_a: assert property (
		!telegram_ok && comm_timeout_period != 16'h0000 && state_reg.wd_state == nomw_pkg::WD_ARMED &&
		state_reg.presc == 23'h000000 && state_reg.remain == 16'h0001 |=>
		(comm_timeout_fault == $past(comm_loss_action_select)) && state_reg.wd_state == nomw_pkg::WD_EXPIRED)
		else $error("timeout raised the wrong indication");

	alarm_clear_a: assert property (
		comm_timeout_alarm && telegram_ok |=> !comm_timeout_alarm)
		else $error("alarm stayed after a valid telegram");

	disabled_idle_a: assert property (
		comm_timeout_period == 16'h0000 |=> state_reg.wd_state == nomw_pkg::WD_IDLE && !comm_timeout_alarm)
		else $error("disabled watchdog left idle");

	ctrl_unused_a: assert property (
		(drive_control_word & ~`NOMW_CTRL_USED_MASK) == 16'h0000)
		else $error("unused control bit set");

	fault_reset_a: assert property (
		req_valid && req_write && req_kind == nomw_pkg::binary_write_object && req_index == 5'h08 &&
		req_wdata[0] |=> fault_reset_req ##1 !fault_reset_req)
		else $error("fault reset request not a single pulse");

	forward_read_a: assert property (
		req_valid && !req_write && req_kind == nomw_pkg::binary_read_object && req_index == 5'h0B |=>
		rsp_valid && rsp_data == {15'h0000, $past(drive_status_flags[10])})
		else $error("forward status object read wrong");

	ramp_range_a: assert property (
		req_valid && req_write && req_kind == nomw_pkg::analog_write_object && req_index == 5'h01 &&
		req_wdata > `NOMW_RAMP_MAX |=> rsp_error && accel_time == $past(accel_time))
		else $error("out-of-range ramp time accepted");

	direction_a: assert property (
		##1 dir_forward == (drive_control_word[`NOMW_CTRL_FWD_BIT] ^ net_speed_reference[15]))
		else $error("direction does not follow bit 2 and sign");

	ao_scale_a: assert property (
		ao_level_a == (analog_out_value_a[15] ? 15'h0000 : analog_out_value_a[14:0]))
		else $error("analog output level scaled wrong");

	rsp_pulse_a: assert property (
		##1 rsp_valid == $past(req_valid))
		else $error("response is not a one-cycle echo of a request");

	bi_readonly_a: assert property (
		req_valid && req_write && req_kind == nomw_pkg::binary_read_object |=> rsp_valid && rsp_error)
		else $error("write to an input object accepted");

	din_read_a: assert property (
		req_valid && !req_write && req_kind == nomw_pkg::binary_read_object && req_index == 5'h11 |=>
		rsp_data == {15'h0000, $past(digital_input_state[0])})
		else $error("first digital input read wrong");

	pct_range_a: assert property (
		req_valid && req_write && req_kind == nomw_pkg::analog_write_object && req_index == 5'h0A &&
		req_wdata > `NOMW_PCT_MAX |=>
		rsp_error && main_pid_manual_setpoint == $past(main_pid_manual_setpoint))
		else $error("out-of-range manual setpoint accepted");

	speed_store_a: assert property (
		req_valid && req_write && req_kind == nomw_pkg::analog_write_object && req_index == 5'h03 |=>
		!rsp_error && net_speed_reference == $past(req_wdata))
		else $error("speed reference write lost");

	dout_store_a: assert property (
		req_valid && req_write && req_kind == nomw_pkg::binary_write_object && req_index == 5'h15 |=>
		digital_output_setting[4] == $past(req_wdata[0]))
		else $error("digital output five not written");

	fault_hold_a: assert property (
		comm_timeout_fault && !(req_valid && req_write && req_kind == nomw_pkg::binary_write_object &&
		req_index == 5'h08 && req_wdata[0]) |=> comm_timeout_fault)
		else $error("communication fault cleared without a reset");

	alarm_status_a: assert property (
		req_valid && !req_write && req_kind == nomw_pkg::binary_read_object && req_index == 5'h08 |=>
		rsp_data == {15'h0000, $past(drive_status_flags[7] | comm_timeout_alarm)})
		else $error("status alarm bit does not carry the watchdog alarm");

	alarm_cov_c: cover property (!comm_timeout_alarm ##1 comm_timeout_alarm ##[1:20] !comm_timeout_alarm);
	fault_cov_c: cover property (comm_timeout_fault ##1 fault_reset_req);
	refuse_cov_c: cover property (rsp_valid && rsp_error);
	dout_cov_c: cover property (digital_output_setting == 5'h1F);
	dir_cov_c: cover property (dir_forward && net_speed_reference[15]);

endmodule

// ### testbench/nomw_master_model.sv
// Network master model that issues object requests and valid telegrams.
`timescale 1ns/1ps
module nomw_master_model (
	input wire logic sys_clk,
	output logic telegram_ok,
	output logic req_valid,
	output logic req_write,
	output nomw_pkg::nomw_kind_type req_kind,
	output logic [4:0] req_index,
	output logic [15:0] req_wdata
);
	initial begin
		telegram_ok = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_kind = nomw_pkg::analog_write_object;
		req_index = 5'h00;
		req_wdata = 16'h0000;
	end

	task automatic access(input logic wr, input nomw_pkg::nomw_kind_type k, input logic [4:0] idx,
		input logic [15:0] wd);
		@(posedge sys_clk);
		#1;
		req_valid = 1'b1;
		req_write = wr;
		req_kind = k;
		req_index = idx;
		req_wdata = wd;
	endtask

	// Released write, index and data fields are inverted so that the design cannot lean on stale values.
	task automatic release_bus();
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		req_write = ~req_write;
		req_index = ~req_index;
		req_wdata = ~req_wdata;
	endtask

	task automatic send_telegram();
		@(posedge sys_clk);
		#1;
		telegram_ok = 1'b1;
		@(posedge sys_clk);
		#1;
		telegram_ok = 1'b0;
	endtask

	task automatic keep_alive(input int count, input int gap);
		repeat (count) begin
			send_telegram();
			repeat (gap) @(posedge sys_clk);
		end
		#1;
	endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the object map and communication watchdog.
`timescale 1ns/1ps
module testbench;
	typedef struct {
		logic err;
		logic [15:0] data;
		logic frr;
	} nomw_exp_type;
	localparam nomw_pkg::nomw_kind_type kind_ana = nomw_pkg::analog_write_object;
	localparam nomw_pkg::nomw_kind_type kind_rd = nomw_pkg::binary_read_object;
	localparam nomw_pkg::nomw_kind_type kind_wr = nomw_pkg::binary_write_object;
	// Refused requests: write flag, kind, index and data packed into one word.
	localparam logic [23:0] bad_req [11] = '{24'h812707, 24'h82FFFF, 24'h8A03E9, 24'h8C8000, 24'h000000,
		24'h0D0000, 24'hA20001, 24'h390000, 24'h560000, 24'h200000, 24'hC00001};
	localparam logic [15:0] lvl [4] = '{16'h7FFF, 16'h8000, 16'h0000, 16'h4A5C};
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic comm_loss_action_select = 1'b0;
	logic [15:0] comm_timeout_period = 16'h0000;
	logic [15:0] drive_status_flags = 16'h0000;
	logic [7:0] digital_input_state = 8'h00;
	logic telegram_ok, req_valid, req_write, rsp_valid, rsp_error, comm_timeout_alarm, comm_timeout_fault;
	logic fault_reset_req, dir_forward, bitv, alarm_seen;
	nomw_pkg::nomw_kind_type req_kind;
	logic [4:0] req_index, digital_output_setting, dout_exp;
	logic [15:0] req_wdata, rsp_data, drive_control_word, ctrl_exp, wd;
	logic [14:0] ao_level_a, ao_level_b;
	wire [11:0][15:0] ana_port;
	logic [15:0] ana_exp [12];
	nomw_exp_type exp_q [$];
	int err_count = 0;
	int cmp_count = 0;
	int seed_val;

	nomw_master_model i_master (.sys_clk, .telegram_ok, .req_valid, .req_write, .req_kind, .req_index, .req_wdata);
	nomw_top #(.TICK_CYCLES(4)) i_dut (.sys_clk, .rst, .telegram_ok, .req_valid, .req_write, .req_kind,
		.req_index, .req_wdata, .comm_timeout_period, .comm_loss_action_select, .drive_status_flags,
		.digital_input_state, .rsp_valid, .rsp_error, .rsp_data, .comm_timeout_alarm, .comm_timeout_fault,
		.fault_reset_req, .drive_control_word, .digital_output_setting, .dir_forward, .ao_level_a, .ao_level_b,
		.accel_time(ana_port[0]), .decel_time(ana_port[1]), .net_speed_reference(ana_port[2]),
		.analog_out_value_a(ana_port[3]), .analog_out_value_b(ana_port[4]), .user_prog_param_a(ana_port[5]),
		.user_prog_param_b(ana_port[6]), .user_prog_param_c(ana_port[7]), .main_pid_auto_setpoint(ana_port[8]),
		.main_pid_manual_setpoint(ana_port[9]), .ext_pid_auto_setpoint(ana_port[10]),
		.ext_pid_manual_setpoint(ana_port[11]));

	initial forever #10 sys_clk = ~sys_clk;

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_rsp(input nomw_exp_type e);
		cmp_val({31'h0, rsp_error}, {31'h0, e.err}, "response error");
		if (!e.err)
			cmp_val({16'h0000, rsp_data}, {16'h0000, e.data}, "response data");
		cmp_val({31'h0, fault_reset_req}, {31'h0, e.frr}, "fault reset pulse");
	endtask

	task automatic stop_test();
		if (exp_q.size() != 0) begin
			err_count++;
			$display("[ERR] %0t responses missing", $time);
		end
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic req(input logic wr, input nomw_pkg::nomw_kind_type k, input int idx, input logic [15:0] wd,
		input logic err, input logic [15:0] dat, input logic frr = 1'b0);
		exp_q.push_back('{err, dat, frr});
		i_master.access(wr, k, idx[4:0], wd);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_flag(input logic fault, input int bound);
		int n;
		for (n = 0; n < bound && (fault ? comm_timeout_fault : comm_timeout_alarm) !== 1'b1; n++)
			cycles(1);
		if (n == bound) begin
			err_count++;
			$display("[ERR] %0t watchdog flag missing", $time);
			stop_test();
		end
	endtask

	// The watcher samples at the edge, so it sees each one-cycle response exactly once.
	always @(posedge sys_clk) begin
		if (comm_timeout_alarm !== 1'b0)
			alarm_seen = 1'b1;
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("[ERR] %0t response without request", $time);
			end else
				cmp_rsp(exp_q.pop_front());
		end
	end

	initial begin
		seed_val = $urandom(32'h05F3E15B);
		cycles(4);
		rst = 1'b0;
		cmp_val({31'h0, |{rsp_valid, rsp_error, rsp_data, comm_timeout_alarm, comm_timeout_fault, fault_reset_req,
			drive_control_word, digital_output_setting, dir_forward, ao_level_a, ao_level_b, ana_port}},
			0, "reset state");
		comm_timeout_period = 16'h0002;
		cycles(30);
		cmp_val({31'h0, comm_timeout_alarm | comm_timeout_fault}, 0, "idle watchdog");
		for (int i = 1; i <= 12; i++) begin
			ana_exp[i-1] = 16'($urandom);
			if (i == 1 || i == 2)
				ana_exp[i-1] = ana_exp[i-1] % 16'h2707;
			if (i == 10 || i == 12)
				ana_exp[i-1] = ana_exp[i-1] % 16'h03E9;
			req(1'b1, kind_ana, i, ana_exp[i-1], 1'b0, ana_exp[i-1]);
		end
		ana_exp[0] = 16'h2706;
		req(1'b1, kind_ana, 1, 16'h2706, 1'b0, 16'h2706);
		for (int j = 0; j < 11; j++)
			req(bad_req[j][23], nomw_pkg::nomw_kind_type'(bad_req[j][22:21]), bad_req[j][20:16],
				bad_req[j][15:0], 1'b1, 16'h0000);
		for (int i = 1; i <= 12; i++)
			req(1'b0, kind_ana, i, 16'h0000, 1'b0, ana_exp[i-1]);
		i_master.release_bus();
		for (int i = 0; i < 12; i++)
			cmp_val({16'h0000, ana_port[i]}, {16'h0000, ana_exp[i]}, "analog object");
		drive_status_flags = 16'($urandom);
		digital_input_state = 8'($urandom);
		for (int i = 1; i <= 24; i++)
			req(1'b0, kind_rd, i, 16'h0000, 1'b0, {15'h0000, i == 1 ? 1'b0 : i <= 16 ?
				drive_status_flags[i-1] : digital_input_state[i-17]});
		for (int i = 1; i <= 21; i++) begin
			wd = 16'($urandom);
			bitv = wd[0] & !(i inside {[9:13], 16});
			if (i <= 16)
				ctrl_exp[i-1] = bitv;
			else
				dout_exp[i-17] = wd[0];
			req(1'b1, kind_wr, i, wd, 1'b0, {15'h0000, bitv}, i == 8 && wd[0]);
		end
		i_master.release_bus();
		cmp_val({16'h0000, drive_control_word}, {16'h0000, ctrl_exp}, "control word");
		cmp_val({27'h0, digital_output_setting}, {27'h0, dout_exp}, "digital outputs");
		for (int i = 1; i <= 21; i++)
			req(1'b0, kind_wr, i, 16'h0000, 1'b0, {15'h0000, i <= 16 ? ctrl_exp[i-1] : dout_exp[i-17]});
		for (int k = 0; k < 4; k++) begin
			wd = ~lvl[k];
			req(1'b1, kind_wr, 3, {15'h0000, k[0]}, 1'b0, {15'h0000, k[0]});
			req(1'b1, kind_ana, 3, k[1] ? 16'h8000 : 16'h0001, 1'b0, k[1] ? 16'h8000 : 16'h0001);
			req(1'b1, kind_ana, 4, lvl[k], 1'b0, lvl[k]);
			req(1'b1, kind_ana, 5, wd, 1'b0, wd);
			i_master.release_bus();
			cycles(1);
			cmp_val({31'h0, dir_forward}, k[0] ^ k[1], "direction");
			cmp_val({17'h0, ao_level_a}, {17'h0, lvl[k][15] ? 15'h0000 : lvl[k][14:0]}, "level a");
			cmp_val({17'h0, ao_level_b}, {17'h0, wd[15] ? 15'h0000 : wd[14:0]}, "level b");
		end
		i_master.send_telegram();
		cycles(7);
		cmp_val({31'h0, comm_timeout_alarm}, 0, "alarm early");
		cycles(1);
		cmp_val({31'h0, comm_timeout_alarm}, 1, "alarm on time");
		cmp_val({31'h0, comm_timeout_fault}, 0, "no fault with alarm");
		i_master.send_telegram();
		cycles(1);
		cmp_val({31'h0, comm_timeout_alarm}, 0, "alarm cleared");
		alarm_seen = 1'b0;
		i_master.keep_alive(10, 5);
		cmp_val({31'h0, alarm_seen}, 0, "alarm while fed");
		for (int i = 6; i <= 11; i++)
			req(1'b0, kind_ana, i, 16'h0000, 1'b0, ana_exp[i-1]);
		i_master.release_bus();
		cmp_val({31'h0, comm_timeout_alarm}, 1, "alarm despite requests");
		req(1'b0, kind_rd, 8, 16'h0000, 1'b0, 16'h0001);
		i_master.release_bus();
		comm_loss_action_select = 1'b1;
		i_master.send_telegram();
		wait_flag(1'b1, 12);
		cmp_val({31'h0, comm_timeout_alarm}, 0, "alarm beside fault");
		i_master.send_telegram();
		cmp_val({31'h0, comm_timeout_fault}, 1, "fault held");
		req(1'b0, kind_rd, 16, 16'h0000, 1'b0, 16'h0001);
		req(1'b1, kind_wr, 8, 16'h0001, 1'b0, 16'h0001, 1'b1);
		i_master.release_bus();
		cycles(1);
		cmp_val({31'h0, comm_timeout_fault}, 0, "fault reset");
		comm_loss_action_select = 1'b0;
		wait_flag(1'b0, 12);
		comm_timeout_period = 16'h0000;
		cycles(2);
		cmp_val({31'h0, comm_timeout_alarm}, 0, "alarm when disabled");
		i_master.send_telegram();
		cycles(30);
		cmp_val({31'h0, comm_timeout_alarm | comm_timeout_fault}, 0, "disabled watchdog");
		cycles(2);
		stop_test();
	end
endmodule
